// ==== inc/aivc_pkg.sv ====
// Package for the analog input value checker: modes, codes, timing.
// Assumes a 25 MHz system clock and a 13-bit signed converter sample.
package aivc_pkg;

  // ****************************************
  // Value codes
  // ****************************************
  localparam logic [15:0] AIVC_OVF_VALUE = 16'h7FFF;
  localparam logic [15:0] AIVC_UDF_VALUE = 16'h8001;
  localparam logic [15:0] AIVC_ZERO      = 16'h0000;

  // Error numbers of the class-four messages
  localparam logic [7:0] AIVC_ERR_OVERLOAD  = 8'h04;
  localparam logic [7:0] AIVC_ERR_OPEN      = 8'h09;
  localparam logic [7:0] AIVC_ERR_PLAUSIBLE = 8'h0A;

  // ****************************************
  // Timing
  // ****************************************
  localparam int AIVC_CLK_HZ       = 25000000;
  localparam int AIVC_RETRY_MS     = 1000;
  localparam int AIVC_RETRY_CYCLES = AIVC_CLK_HZ / 1000 * AIVC_RETRY_MS;

  // ****************************************
  // Channel modes
  // ****************************************
  typedef enum logic [2:0] {
    AIVC_M_BIP10, AIVC_M_BIP5, AIVC_M_UNI10, AIVC_M_UNI5,
    AIVC_M_MA4_20, AIVC_M_MA0_20, AIVC_M_DIFF, AIVC_M_OFF
  } aivc_mode_t;

  // Per-channel sample from the front end
  typedef struct packed {
    logic        over;      // Converter above range
    logic        under;     // Converter below range
    logic        plaus;     // Beyond range by 2..3 percent
    logic        over_cur;  // Shunt current too high
    logic        low_cur;   // Current below about 3 mA
    logic [15:0] value;     // Signed scaled value
  } aivc_sample_t;

  // Error message toward the controller
  typedef struct packed {
    logic        error_class_four;
    logic [2:0]  chan;
    logic [7:0]  number;
  } aivc_msg_t;

endpackage

// ==== verilog/aivc_top.sv ====
// Analog input value checker: range codes, shunt guard, differential.
// Assumes samples arrive synchronous to SYS_CLK with a one-cycle valid.
// Function
// [R1] Overflow always reports +32767 and underflow -32767 in any case; the even half of a differential pair is parked without its range flags.
// A channel in AIVC_M_OFF publishes no value, so it reports neither code.
// [R2] The 0..20 mA mode flags overflow but never underflow.
// [R3] With plausibility watch on, a 2..3 percent excess raises error 10.
// [R4] Excess current in current modes opens the shunt, reports overflow.
// [R5] An open shunt is retried about once a second until current is sane.
// [R6] While the shunt guard is active the LED lights and error 4 stored.
// [R7] In 4..20 mA a current under about 3 mA is open circuit, underflow.
// [R8] With open watch on, open circuit lights the LED and stores error 9.
// [R9] Differential mode pairs two adjacent channels into one value.
// [R10] The pair value is the higher channel minus the lower channel.
// [R11] The pair value is placed at the odd channel of the pair.
// [R12] Each value is a signed 16-bit word with bit 15 as sign.
// [R13] Voltage modes give overflow above and underflow below the range.
// [R14] Each channel mode selects its range checks and error handling.
`timescale 1ns/1ps
module aivc_top
  import aivc_pkg::*;
#(
  parameter int NCH          = 8,
  parameter int RETRY_CYCLES = AIVC_RETRY_CYCLES
)(
  input  wire logic                SYS_CLK,
  input  wire logic                RSTN,
  input  wire aivc_mode_t          MODE [NCH],
  input  wire logic [NCH-1:0]      PLAUS_EN,
  input  wire logic [NCH-1:0]      OPEN_EN,
  input  wire logic                SAMPLE_VALID,
  input  wire logic [2:0]          SAMPLE_CHAN,
  input  wire aivc_sample_t        SAMPLE,
  output logic [NCH-1:0]           SHUNT_ON,
  output logic                     OVL_LED,
  output logic                     IMG_VALID,
  output logic [2:0]               IMG_CHAN,
  output logic [15:0]              IMG_VALUE,
  output logic                     MSG_VALID,
  output aivc_msg_t                MSG
);

  // ****************************************
  // Decode of the incoming sample
  // ****************************************
  localparam int RW = $clog2(RETRY_CYCLES + 1);

  aivc_mode_t  mode;
  wire logic   is_cur;
  wire logic   is_diff;
  wire logic   odd;
  wire logic   shunt_open;
  wire logic   open_ckt;
  wire logic   over_hit;
  wire logic   under_hit;
  wire logic   plaus_hit;
  wire logic   guard_hit;
  logic [15:0] next_value;
  logic [15:0] pair_lo;
  logic [NCH-1:0] guard;
  logic [NCH-1:0] open_flag;
  logic [RW-1:0]  retry_cnt;
  wire logic   retry_tick;
  wire logic [16:0] diff_wide;

  assign mode       = MODE[SAMPLE_CHAN];
  assign is_cur     = (mode == AIVC_M_MA4_20) || (mode == AIVC_M_MA0_20);
  assign is_diff    = (mode == AIVC_M_DIFF); // [R14]
  assign odd        = SAMPLE_CHAN[0];
  assign shunt_open = is_cur && !SHUNT_ON[SAMPLE_CHAN];
  assign guard_hit  = is_cur && SAMPLE.over_cur; // [R4]
  // Open circuit only exists where a live zero is offset to 4 mA
  assign open_ckt   = (mode == AIVC_M_MA4_20) && SAMPLE.low_cur; // [R7]
  assign over_hit   = SAMPLE.over || guard_hit || shunt_open; // [R1] [R13]
  // The 0..20 mA range has no underflow code
  assign under_hit  = (SAMPLE.under && mode != AIVC_M_MA0_20) // [R2]
                      || open_ckt;
  assign plaus_hit  = PLAUS_EN[SAMPLE_CHAN] && SAMPLE.plaus
                      && (SAMPLE.over || under_hit); // [R3]
  // Higher minus lower, saturated to the error codes
  assign diff_wide  = {SAMPLE.value[15], SAMPLE.value}
                      - {pair_lo[15], pair_lo}; // [R10]

  // Value selection with overflow taking priority
  always_comb begin
    if (over_hit) begin
      next_value = AIVC_OVF_VALUE; // [R1]
    end else if (under_hit) begin
      next_value = AIVC_UDF_VALUE; // [R1]
    end else if (is_diff) begin
      if (diff_wide[16] != diff_wide[15])
        next_value = diff_wide[16] ? AIVC_UDF_VALUE : AIVC_OVF_VALUE;
      else if (diff_wide[15:0] == 16'h8000)
        next_value = AIVC_UDF_VALUE;
      else
        next_value = diff_wide[15:0];
    end else begin
      next_value = SAMPLE.value; // [R12]
    end
  end

  // ****************************************
  // Input image
  // ****************************************
  // Even half of a pair only parks its value; it is not published
  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      pair_lo   <= AIVC_ZERO;
      IMG_VALID <= 1'b0;
      IMG_CHAN  <= 3'h0;
      IMG_VALUE <= AIVC_ZERO;
    end else begin
      IMG_VALID <= 1'b0;
      if (SAMPLE_VALID && is_diff && !odd) begin
        pair_lo <= SAMPLE.value; // [R9]
      end else if (SAMPLE_VALID && mode != AIVC_M_OFF) begin
        IMG_VALID <= 1'b1;
        IMG_CHAN  <= SAMPLE_CHAN; // [R11]
        IMG_VALUE <= next_value;
      end
    end
  end

  // ****************************************
  // Shunt guard and retry
  // ****************************************
  // One shared second tick; a retry may come early by up to one second
  assign retry_tick = (retry_cnt == RW'(RETRY_CYCLES - 1));

  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN)
      retry_cnt <= '0;
    else if (retry_tick)
      retry_cnt <= '0;
    else
      retry_cnt <= retry_cnt + RW'(1);
  end

  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      wire logic hit = SAMPLE_VALID && SAMPLE_CHAN == 3'(g);
      always_ff @(posedge SYS_CLK or negedge RSTN) begin
        if (!RSTN) begin
          SHUNT_ON[g]  <= 1'b1;
          guard[g]     <= 1'b0;
          open_flag[g] <= 1'b0;
        end else begin
          if (hit && guard_hit) begin
            SHUNT_ON[g] <= 1'b0; // [R4]
            guard[g]    <= 1'b1;
          end else if (retry_tick && !SHUNT_ON[g]) begin
            SHUNT_ON[g] <= 1'b1; // [R5]
          end else if (hit && SHUNT_ON[g]) begin
            guard[g] <= 1'b0; // [R5]
          end
          if (hit)
            open_flag[g] <= open_ckt && OPEN_EN[g]; // [R8]
        end
      end
      // An open shunt must come back on the shared tick
      a_retry: assert property (@(posedge SYS_CLK) // [R5]
        disable iff (!RSTN)
        retry_tick && !SHUNT_ON[g] && !(hit && guard_hit) |=> SHUNT_ON[g])
        else $error("shunt not retried");
    end
  endgenerate

  // ****************************************
  // LED and error messages
  // ****************************************
  wire logic [7:0] msg_num = guard_hit ? AIVC_ERR_OVERLOAD
                           : (open_ckt && OPEN_EN[SAMPLE_CHAN])
                             ? AIVC_ERR_OPEN : AIVC_ERR_PLAUSIBLE;
  wire logic msg_hit = guard_hit || plaus_hit
                       || (open_ckt && OPEN_EN[SAMPLE_CHAN]);

  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      OVL_LED   <= 1'b0;
      MSG_VALID <= 1'b0;
      MSG       <= '0;
    end else begin
      OVL_LED   <= |guard || |open_flag; // [R6] [R8]
      MSG_VALID <= SAMPLE_VALID && msg_hit;
      if (SAMPLE_VALID && msg_hit) begin
        MSG.error_class_four <= 1'b1; // [R3] [R6] [R8]
        MSG.chan             <= SAMPLE_CHAN;
        MSG.number           <= msg_num;
      end
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  a_over_code: assert property (@(posedge SYS_CLK) disable iff (!RSTN) // [R1]
    SAMPLE_VALID && SAMPLE.over && mode != AIVC_M_OFF && !(is_diff && !odd)
    |=> IMG_VALID && IMG_VALUE == 16'h7FFF)
    else $error("overflow code missing");
  a_no_under_020: assert property (@(posedge SYS_CLK) disable iff (!RSTN) // [R2]
    SAMPLE_VALID && mode == AIVC_M_MA0_20 && !SAMPLE.over
    && SHUNT_ON[SAMPLE_CHAN] && !SAMPLE.over_cur |=> IMG_VALUE != 16'h8001)
    else $error("underflow flagged in 0..20 mA");
  a_guard_shunt: assert property (@(posedge SYS_CLK) disable iff (!RSTN) // [R4]
    SAMPLE_VALID && guard_hit |=> !SHUNT_ON[$past(SAMPLE_CHAN)])
    else $error("shunt not opened");
  a_guard_msg: assert property (@(posedge SYS_CLK) disable iff (!RSTN) // [R6]
    SAMPLE_VALID && guard_hit |=> MSG_VALID && MSG.number == 8'h04 ##1 OVL_LED)
    else $error("overload message or led missing");
  a_open_under: assert property (@(posedge SYS_CLK) disable iff (!RSTN) // [R7]
    SAMPLE_VALID && open_ckt && !over_hit |=> IMG_VALUE == 16'h8001)
    else $error("open circuit not underflow");
  a_open_msg: assert property (@(posedge SYS_CLK) disable iff (!RSTN) // [R8]
    SAMPLE_VALID && open_ckt && OPEN_EN[SAMPLE_CHAN] && !guard_hit
    |=> MSG_VALID && MSG.number == 8'h09)
    else $error("open circuit message missing");
  a_plaus_msg: assert property (@(posedge SYS_CLK) disable iff (!RSTN) // [R3]
    SAMPLE_VALID && plaus_hit |=> MSG_VALID && MSG.error_class_four)
    else $error("plausibility message missing");
  a_diff_odd: assert property (@(posedge SYS_CLK) disable iff (!RSTN) // [R11]
    IMG_VALID && MODE[IMG_CHAN] == AIVC_M_DIFF |-> IMG_CHAN[0])
    else $error("pair value at even channel");

endmodule

// ==== bench/aivc_fe_model.sv ====
// Front-end model: converter samples toward the value checker.
// Assumes the checker takes a sample on the rising edge of clk.
`timescale 1ns/1ps
module aivc_fe_model
  import aivc_pkg::*;
(
  input  wire logic         clk,
  input  wire logic [7:0]   shunt_on,
  output logic              sample_valid,
  output logic [2:0]        sample_chan,
  output aivc_sample_t      sample
);
  // ****************************************
  // Sample transfer
  // ****************************************
  // One sample a call; lines are inverted afterwards so stale data
  // can never pass for a fresh sample
  task automatic send(input logic [2:0] ch, input aivc_sample_t s);
    aivc_sample_t d;
    @(posedge clk);
    #1;
    d            = s;
    d.over_cur   = s.over_cur & shunt_on[ch];  // Open shunt, no current
    sample_valid = 1'b1;
    sample_chan  = ch;
    sample       = d;
    @(posedge clk);
    #1;
    sample_valid = 1'b0;
    sample       = ~sample;
  endtask
  // Idle lines at time zero
  initial begin
    sample_valid = 1'b0;
    sample_chan  = 3'h0;
    sample       = '0;
  end
endmodule

// ==== bench/aivc_top_tb_top.sv ====
// Self-checking bench of the analog input value checker.
// Assumes the front-end model and a 20-cycle shunt retry.
`timescale 1ns/1ps
module aivc_top_tb_top
  import aivc_pkg::*;
;
  // ****************************************
  // Signals and instances
  // ****************************************
  logic         sys_clk = 1'b0;
  logic         rstn = 1'b0;
  aivc_mode_t   mode [8] = '{AIVC_M_BIP10, AIVC_M_BIP5, AIVC_M_UNI10,
    AIVC_M_UNI5, AIVC_M_MA4_20, AIVC_M_MA0_20, AIVC_M_DIFF, AIVC_M_DIFF};
  logic [7:0]   plaus_en = 8'h01;
  logic [7:0]   open_en = 8'h10;
  logic         s_valid, img_valid, msg_valid, ovl_led;
  logic [2:0]   s_chan, img_chan, ch;
  logic [7:0]   shunt_on;
  logic [15:0]  img_value, a, b;
  aivc_sample_t s;
  aivc_sample_t s_drv;
  aivc_msg_t    msg;
  int           n_mismatch = 0;
  int           tests_run = 0;
  always #20 sys_clk = ~sys_clk;
  aivc_fe_model i_aivc_fe_model (.clk(sys_clk), .shunt_on(shunt_on),
    .sample_valid(s_valid), .sample_chan(s_chan), .sample(s_drv));
  aivc_top #(.NCH(8), .RETRY_CYCLES(20)) i_aivc_top (.SYS_CLK(sys_clk),
    .RSTN(rstn), .MODE(mode), .PLAUS_EN(plaus_en), .OPEN_EN(open_en),
    .SAMPLE_VALID(s_valid), .SAMPLE_CHAN(s_chan), .SAMPLE(s_drv),
    .SHUNT_ON(shunt_on), .OVL_LED(ovl_led), .IMG_VALID(img_valid),
    .IMG_CHAN(img_chan), .IMG_VALUE(img_value), .MSG_VALID(msg_valid),
    .MSG(msg));
  // ****************************************
  // Checks and expectations
  // ****************************************
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // Overflow wins; 0..20 mA ignores the underflow flag
  function automatic logic [15:0] exp_val(aivc_mode_t m, aivc_sample_t x);
    if (x.over) return AIVC_OVF_VALUE;
    if (x.under && m != AIVC_M_MA0_20) return AIVC_UDF_VALUE;
    return x.value;
  endfunction
  // Send one sample, then look at the one-cycle image and message pulses
  task automatic xfer(input logic [2:0] c, input aivc_sample_t x,
    input logic iv, input logic [15:0] ev, input logic mv,
    input logic [7:0] en);
    i_aivc_fe_model.send(c, x);
    // Send returns just after the taking edge, while the pulses stand
    chk({15'h0, img_valid}, {15'h0, iv});
    if (iv) chk({13'h0, img_chan}, {13'h0, c});
    if (iv) chk(img_value, ev);
    chk({15'h0, msg_valid}, {15'h0, mv});
    if (mv) chk({7'h0, msg.error_class_four, msg.number}, {8'h01, en});
    if (mv) chk({13'h0, msg.chan}, {13'h0, c});
  endtask
  task automatic led(input logic e);
    @(posedge sys_clk);
    #1;
    chk({15'h0, ovl_led}, {15'h0, e});
  endtask
  task automatic close_out();
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Watchdog: the tests need well under 1000 cycles
  initial begin
    #160000;
    n_mismatch++;
    close_out();
  end
  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    void'($urandom(38113));
    repeat (5) @(posedge sys_clk);
    #1;
    rstn = 1'b1;
    // Random voltage samples with random range and plausibility flags
    repeat (40) begin
      ch = 3'($urandom_range(3, 0));
      s = {3'($urandom), 2'b00, 16'($urandom)};
      xfer(ch, s, 1'b1, exp_val(mode[ch], s), plaus_en[ch] & s.plaus &
        (s.over | s.under), AIVC_ERR_PLAUSIBLE);
    end
    // A switched-off channel publishes nothing
    mode[3] = AIVC_M_OFF;
    xfer(3'h3, s, 1'b0, AIVC_ZERO, 1'b0, 8'h00);
    mode[3] = AIVC_M_UNI5;
    s = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 16'h1234};
    xfer(3'h5, s, 1'b1, 16'h1234, 1'b0, 8'h00);
    s = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 16'h0040};
    xfer(3'h4, s, 1'b1, AIVC_UDF_VALUE, 1'b1, AIVC_ERR_OPEN);
    led(1'b1);
    s.low_cur = 1'b0;
    xfer(3'h4, s, 1'b1, 16'h0040, 1'b0, 8'h00);
    led(1'b0);
    s.over_cur = 1'b1;
    xfer(3'h5, s, 1'b1, AIVC_OVF_VALUE, 1'b1, AIVC_ERR_OVERLOAD);
    // Looked at before the shared tick can reconnect the shunt
    chk({15'h0, shunt_on[5]}, 16'h0000);
    led(1'b1);
    for (int k = 0; k < 40 && shunt_on[5] !== 1'b1; k++) @(posedge sys_clk);
    #1;
    chk({15'h0, shunt_on[5]}, 16'h0001);
    s.over_cur = 1'b0;
    xfer(3'h5, s, 1'b1, 16'h0040, 1'b0, 8'h00);
    led(1'b0);
    // Pair corner: the difference runs past full scale and saturates
    xfer(3'h6, '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 16'h8002}, 1'b0, AIVC_ZERO,
      1'b0, 8'h00);
    xfer(3'h7, '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 16'h7000}, 1'b1,
      AIVC_OVF_VALUE, 1'b0, 8'h00);
    // Differential pair: even side parked, odd side gets the difference
    a = 16'($urandom_range(16000, 0)) - 16'h1F40;
    b = 16'($urandom_range(16000, 0)) - 16'h1F40;
    xfer(3'h6, '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, a}, 1'b0, a, 1'b0, 8'h00);
    xfer(3'h7, '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, b}, 1'b1, b - a, 1'b0,
      8'h00);
    close_out();
  end
endmodule
